// [pctm_pkg.sv]
// Package with register map, field layout, reset values and interval arithmetic for the card timing block.
package pctm_pkg;

  // Register indexes; byte address on the bus is four times the index.
  localparam logic [7:0] IDX_IOWIN_CTRL = 8'h07;
  localparam logic [7:0] IDX_SETUP0 = 8'h3a;
  localparam logic [7:0] IDX_STROBE0 = 8'h3b;
  localparam logic [7:0] IDX_SETUP1 = 8'h3d;
  localparam logic [7:0] IDX_STROBE1 = 8'h3e;
  localparam logic [7:0] IDX_ACCESS = 8'h40;
  localparam logic [7:0] IDX_STATUS = 8'h41;

  // Reset values.
  localparam logic [7:0] RST_IOWIN_CTRL = 8'h00;
  localparam logic [7:0] RST_SETUP0 = 8'h01;
  localparam logic [7:0] RST_STROBE0 = 8'h05;
  localparam logic [7:0] RST_SETUP1 = 8'h01;
  localparam logic [7:0] RST_STROBE1 = 8'h14;
  localparam logic [7:0] RST_ACCESS = 8'h00;

  // Timing register fields.
  localparam int PRESC_HI = 7;
  localparam int PRESC_LO = 6;
  localparam int MULT_HI = 5;
  localparam int MULT_LO = 0;

  // I/O window control: timer set select for window 0 and window 1.
  localparam int IOWIN0_SET_BIT = 3;
  localparam int IOWIN1_SET_BIT = 7;

  // Access control register fields.
  localparam int ACC_KIND_HI = 1;
  localparam int ACC_KIND_LO = 0;
  localparam int ACC_WIN_BIT = 2;
  localparam int ACC_MSET_BIT = 3;
  localparam int ACC_START_BIT = 7;

  // Interval counter width: 4096 * 63 + 1 fits in 18 bits.
  localparam int LEN_W = 18;
  localparam logic [17:0] LEN_ONE = 18'h00001;

  typedef enum logic [1:0] {
    PCTM_MEM_RD = 2'b00,
    PCTM_MEM_WR = 2'b01,
    PCTM_IO_RD = 2'b10,
    PCTM_IO_WR = 2'b11
  } pctm_kind_t;

  typedef enum logic [1:0] {
    PCTM_IDLE = 2'b00,
    PCTM_SETUP = 2'b01,
    PCTM_STROBE = 2'b10
  } pctm_state_t;

  // Length = prescale weight times multiplier, plus one.
  function automatic logic [17:0] interval_len(input logic [7:0] v);
    logic [17:0] m;
    m = {12'h000, v[MULT_HI:MULT_LO]};
    case (v[PRESC_HI:PRESC_LO])
      2'b00: m = m;
      2'b01: m = m << 4;
      2'b10: m = m << 8;
      2'b11: m = m << 12;
      default: m = m;
    endcase
    return m + LEN_ONE;
  endfunction

endpackage

// [pctm_ahb_front.sv]
// AHB-Lite address-phase decode and write data-phase pipeline for the card timing block.
module pctm_ahb_front (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // AHB-Lite address phase
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  // Decoded access
  output logic rd_req_o,
  output logic [7:0] rd_idx_o,
  output logic wr_stb_o,
  output logic [7:0] wr_idx_o
);

  logic word_ok;
  logic take;
  logic wr_stb_reg;
  logic [7:0] wr_idx_reg;

  // Only whole aligned words are decoded; anything else writes nothing and leaves hrdata at the value of the last decoded read.
  assign word_ok = (hsize_i == 3'h2) && (haddr_i[1:0] == 2'h0) && (haddr_i[31:10] == 22'h000000);
  assign take = hsel_i && htrans_i[1] && hready_i && word_ok;
  assign rd_req_o = take && !hwrite_i;
  assign rd_idx_o = haddr_i[9:2];
  assign wr_stb_o = wr_stb_reg;
  assign wr_idx_o = wr_idx_reg;

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      wr_stb_reg <= 1'b0;
      wr_idx_reg <= 8'h00;
    end
    else if (ce_i)
    begin
      wr_stb_reg <= take && hwrite_i;
      wr_idx_reg <= haddr_i[9:2];
    end
  end

endmodule

// [pctm_interval.sv]
// Down counter that times one setup or strobe interval of a card access.
module pctm_interval (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Control
  input wire logic load_i,
  input wire logic [17:0] len_i,
  // Status
  output logic last_o
);

  logic [17:0] cnt_reg;
  logic [17:0] cnt_next;

  // The last cycle of an interval is the one in which the count stands at one.
  assign last_o = (cnt_reg == pctm_pkg::LEN_ONE);
  assign cnt_next = load_i ? len_i : (cnt_reg == 18'h00000) ? cnt_reg : cnt_reg - pctm_pkg::LEN_ONE;

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
      cnt_reg <= 18'h00000;
    else if (ce_i)
      cnt_reg <= cnt_next;
  end

endmodule

// [pctm_card_timing.sv]
// Card access cycle timing generator with AHB-Lite register access.
// Function
// [R1] Timing registers apply from the next interval load.
// [R2] I/O window control bits 3/7 pick set.
// [R3] Two setup registers, index 3Ah and 3Dh.
// [R4] Wait setup interval before any strobe.
// [R5] Setup lasts weight times multiplier plus one.
// [R6] Setup prescale codes weigh 1, 16, 256, 4096.
// [R7] Setup multiplier is unsigned 0 to 63.
// [R8] Lengths counted in internal clock cycles.
// [R9] Two strobe registers, index 3Bh and 3Eh.
// [R10] Strobe active weight times multiplier plus one.
// [R11] Strobe multiplier resets 5h and 14h.
// [R12] Strobe multiplier is unsigned 0 to 63.
// [R13] Same timing for OE, WE, IORD, IOWR.
// [R14] Strobe prescale codes weigh 1, 16, 256, 4096.
// [R15] Setup then strobe, reload at access start.
// [R16] Counters reach 4096 times 63 plus one.
//
// Decided for this implementation: the AHB-Lite register port.
module pctm_card_timing (
  // Clock, reset and clock enable
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Card command strobes, active low
  output logic card_oe_n_o,
  output logic card_we_n_o,
  output logic card_iord_n_o,
  output logic card_iowr_n_o,
  // Access activity
  output logic busy_o
);

  // Bus decode.
  logic rd_req;
  logic [7:0] rd_idx;
  logic wr_stb;
  logic [7:0] wr_idx;

  // Registers.
  logic [7:0] iowin_reg;
  logic [7:0] setup0_reg;
  logic [7:0] strobe0_reg;
  logic [7:0] setup1_reg;
  logic [7:0] strobe1_reg;
  logic [7:0] access_reg;
  logic [31:0] hrdata_reg;

  // Access sequencing.
  pctm_pkg::pctm_state_t state_reg;
  pctm_pkg::pctm_state_t state_next;
  logic [1:0] kind_reg;
  logic set_reg;
  logic oe_n_reg;
  logic we_n_reg;
  logic iord_n_reg;
  logic iowr_n_reg;
  logic busy_reg;

  // Combinational selection.
  logic wr_iowin;
  logic wr_setup0;
  logic wr_strobe0;
  logic wr_setup1;
  logic wr_strobe1;
  logic wr_access;
  logic start;
  logic [1:0] req_kind;
  logic req_is_io;
  logic req_set;
  logic [7:0] setup_sel;
  logic [17:0] setup_len;
  logic [17:0] strobe_len;
  logic [17:0] load_len;
  logic timer_load;
  logic timer_last;
  logic [7:0] status_val;
  logic [7:0] rd_val;
  logic enter_strobe;
  logic leave_strobe;

  pctm_ahb_front u_front (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .hsel_i(hsel_i),
    .haddr_i(haddr_i),
    .htrans_i(htrans_i),
    .hwrite_i(hwrite_i),
    .hsize_i(hsize_i),
    .hready_i(hready_i),
    .rd_req_o(rd_req),
    .rd_idx_o(rd_idx),
    .wr_stb_o(wr_stb),
    .wr_idx_o(wr_idx)
  );

  // Write decode; the data phase carries hwdata, so the index was caught in the address phase.
  assign wr_iowin = wr_stb && (wr_idx == pctm_pkg::IDX_IOWIN_CTRL);
  assign wr_setup0 = wr_stb && (wr_idx == pctm_pkg::IDX_SETUP0); // see [R3]
  assign wr_setup1 = wr_stb && (wr_idx == pctm_pkg::IDX_SETUP1); // see [R3]
  assign wr_strobe0 = wr_stb && (wr_idx == pctm_pkg::IDX_STROBE0); // see [R9]
  assign wr_strobe1 = wr_stb && (wr_idx == pctm_pkg::IDX_STROBE1); // see [R9]
  assign wr_access = wr_stb && (wr_idx == pctm_pkg::IDX_ACCESS);

  // A start request while an access runs is dropped; software polls the busy bit first.
  assign start = wr_access && hwdata_i[pctm_pkg::ACC_START_BIT] && (state_reg == pctm_pkg::PCTM_IDLE);
  assign req_kind = hwdata_i[pctm_pkg::ACC_KIND_HI:pctm_pkg::ACC_KIND_LO];
  assign req_is_io = req_kind[1];

  // I/O cycles take their timer set from the window control bit of their window.
  assign req_set = !req_is_io ? hwdata_i[pctm_pkg::ACC_MSET_BIT] :
                   hwdata_i[pctm_pkg::ACC_WIN_BIT] ? iowin_reg[pctm_pkg::IOWIN1_SET_BIT] :
                   iowin_reg[pctm_pkg::IOWIN0_SET_BIT]; // see [R2]

  // Lengths are computed from live register contents at each load, so a rewrite is seen at the next load.
  assign setup_sel = req_set ? setup1_reg : setup0_reg; // see [R1]
  assign setup_len = pctm_pkg::interval_len(setup_sel); // see [R5] [R6] [R7]
  assign strobe_len = pctm_pkg::interval_len(set_reg ? strobe1_reg : strobe0_reg); // see [R10] [R12] [R14]

  // One counter serves both intervals: setup on start, strobe when setup ends.
  assign enter_strobe = (state_reg == pctm_pkg::PCTM_SETUP) && timer_last; // see [R4] [R15]
  assign leave_strobe = (state_reg == pctm_pkg::PCTM_STROBE) && timer_last;
  assign timer_load = start || enter_strobe; // see [R15]
  assign load_len = start ? setup_len : strobe_len;

  pctm_interval u_interval (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .load_i(timer_load),
    .len_i(load_len), // see [R16] [R8]
    .last_o(timer_last)
  );

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      pctm_pkg::PCTM_IDLE:
      begin
        if (start)
          state_next = pctm_pkg::PCTM_SETUP;
      end
      pctm_pkg::PCTM_SETUP:
      begin
        if (timer_last)
          state_next = pctm_pkg::PCTM_STROBE;
      end
      pctm_pkg::PCTM_STROBE:
      begin
        if (timer_last)
          state_next = pctm_pkg::PCTM_IDLE;
      end
      default: state_next = pctm_pkg::PCTM_IDLE;
    endcase
  end

  // Status: busy, in setup, in strobe, timer set in use, kind of last access.
  assign status_val = {2'h0, kind_reg, set_reg,
                       state_reg == pctm_pkg::PCTM_STROBE,
                       state_reg == pctm_pkg::PCTM_SETUP,
                       state_reg != pctm_pkg::PCTM_IDLE};

  assign rd_val = (rd_idx == pctm_pkg::IDX_IOWIN_CTRL) ? iowin_reg :
                  (rd_idx == pctm_pkg::IDX_SETUP0) ? setup0_reg :
                  (rd_idx == pctm_pkg::IDX_STROBE0) ? strobe0_reg :
                  (rd_idx == pctm_pkg::IDX_SETUP1) ? setup1_reg :
                  (rd_idx == pctm_pkg::IDX_STROBE1) ? strobe1_reg :
                  (rd_idx == pctm_pkg::IDX_ACCESS) ? access_reg :
                  (rd_idx == pctm_pkg::IDX_STATUS) ? status_val : 8'h00;

  // Bus answer: zero wait states, always OKAY, unmapped reads return zero.
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
      hrdata_reg <= 32'h00000000;
    else if (ce_i && rd_req)
      hrdata_reg <= {24'h000000, rd_val};
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      iowin_reg <= pctm_pkg::RST_IOWIN_CTRL;
      setup0_reg <= pctm_pkg::RST_SETUP0;
      setup1_reg <= pctm_pkg::RST_SETUP1;
    end
    else if (ce_i)
    begin
      if (wr_iowin)
        iowin_reg <= hwdata_i[7:0];
      if (wr_setup0)
        setup0_reg <= hwdata_i[7:0];
      if (wr_setup1)
        setup1_reg <= hwdata_i[7:0];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      strobe0_reg <= pctm_pkg::RST_STROBE0; // see [R11]
      strobe1_reg <= pctm_pkg::RST_STROBE1; // see [R11]
    end
    else if (ce_i)
    begin
      if (wr_strobe0)
        strobe0_reg <= hwdata_i[7:0];
      if (wr_strobe1)
        strobe1_reg <= hwdata_i[7:0];
    end
  end

  // The start bit is not stored; it reads back as zero.
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
      access_reg <= pctm_pkg::RST_ACCESS;
    else if (ce_i && wr_access)
      access_reg <= {4'h0, hwdata_i[3:0]};
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      state_reg <= pctm_pkg::PCTM_IDLE;
      kind_reg <= 2'h0;
      set_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      state_reg <= state_next;
      if (start)
      begin
        kind_reg <= req_kind;
        set_reg <= req_set;
      end
    end
  end

  // Strobes switch on the same edge as the state, so each stays low exactly one strobe interval.
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      iord_n_reg <= 1'b1;
      iowr_n_reg <= 1'b1;
    end
    else if (ce_i)
    begin
      if (enter_strobe)
      begin
        oe_n_reg <= kind_reg != pctm_pkg::PCTM_MEM_RD; // see [R13]
        we_n_reg <= kind_reg != pctm_pkg::PCTM_MEM_WR; // see [R13]
        iord_n_reg <= kind_reg != pctm_pkg::PCTM_IO_RD; // see [R13]
        iowr_n_reg <= kind_reg != pctm_pkg::PCTM_IO_WR; // see [R13]
      end
      else if (leave_strobe)
      begin
        oe_n_reg <= 1'b1;
        we_n_reg <= 1'b1;
        iord_n_reg <= 1'b1;
        iowr_n_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
      busy_reg <= 1'b0;
    else if (ce_i)
      busy_reg <= state_next != pctm_pkg::PCTM_IDLE;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      hreadyout_o <= 1'b0;
      hresp_o <= 1'b0;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  assign hrdata_o = hrdata_reg;
  assign card_oe_n_o = oe_n_reg;
  assign card_we_n_o = we_n_reg;
  assign card_iord_n_o = iord_n_reg;
  assign card_iowr_n_o = iowr_n_reg;
  assign busy_o = busy_reg;

endmodule

// [pctm_card_model.sv]
// Behavioural card that times how long the host's command strobes stay low.
module pctm_card_model (
  // Clock
  input wire logic mclk_i,
  // Strobes from the adapter, active low: oe, we, iord, iowr
  input wire logic [3:0] stb_n_i,
  // Observations
  output int low_len_o,
  output logic [1:0] kind_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic was_low = 1'b0;
  initial
  begin
    low_len_o = 0;
    kind_o = 2'h0;
  end
  // The card counts adapter clock periods, so the figure scales with that clock.
  always @(posedge mclk_i)
  begin
    if (stb_n_i != 4'hf)
    begin
      low_len_o <= was_low ? low_len_o + 1 : 1;
      kind_o <= stb_n_i[3] ? (stb_n_i[2] ? (stb_n_i[1] ? 2'h3 : 2'h2) : 2'h1) : 2'h0;
    end
    was_low <= (stb_n_i != 4'hf);
  end
endmodule

// [pctm_card_timing_properties.sv]
// Concurrent checks on the ports of the card timing block.
module pctm_card_timing_props (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Observed outputs
  input wire logic hreadyout_o,
  input wire logic card_oe_n_o,
  input wire logic card_we_n_o,
  input wire logic card_iord_n_o,
  input wire logic card_iowr_n_o,
  input wire logic busy_o
);
  logic [3:0] stb;
  assign stb = {card_oe_n_o, card_we_n_o, card_iord_n_o, card_iowr_n_o};
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);
  AST_ONE_STB: assert property ($countones(~stb) <= 1)
    else $error("two strobes low at once");
  AST_IDLE_HIGH: assert property (!busy_o |-> stb == 4'hf)
    else $error("strobe low while idle");
  AST_SETUP_FIRST: assert property ($rose(busy_o) |-> stb == 4'hf)
    else $error("strobe low at access start");
  AST_BUSY_MIN: assert property ($rose(busy_o) |=> busy_o)
    else $error("access shorter than two cycles");
  AST_STB_AFTER: assert property ($fell(&stb) |-> $past(busy_o))
    else $error("strobe without setup");
  AST_END_TOGETHER: assert property ($rose(&stb) |-> !busy_o)
    else $error("busy outlives strobe");
  AST_STB_HOLD: assert property (stb != 4'hf && $past(stb) != 4'hf |-> $stable(stb))
    else $error("strobe changed while low");
  AST_READY: assert property ($past(rstn_i) |-> hreadyout_o)
    else $error("slave not ready");
endmodule

bind pctm_card_timing pctm_card_timing_props i_props (.mclk_i(mclk_i), .rstn_i(rstn_i),
  .hreadyout_o(hreadyout_o), .card_oe_n_o(card_oe_n_o), .card_we_n_o(card_we_n_o),
  .card_iord_n_o(card_iord_n_o), .card_iowr_n_o(card_iowr_n_o), .busy_o(busy_o));

// [testbench.sv]
// Self-checking bench for the card timing block.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic hsel_i = 1'b0;
  logic hwrite_i = 1'b0;
  logic [1:0] htrans_i = 2'h0;
  logic [31:0] haddr_i = 32'h0;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o;
  logic hreadyout_o;
  logic hresp_o;
  logic busy_o;
  logic [3:0] stb;
  logic [1:0] kind_seen;
  int len_seen;
  int n_mismatch = 0;
  int n_tests = 0;
  logic [31:0] seed = 32'h0000905a;
  int w[4] = '{1, 16, 256, 4096};
  logic [7:0] ri[4] = '{8'h3a, 8'h3b, 8'h3d, 8'h3e};
  logic [7:0] rv[4] = '{8'h01, 8'h05, 8'h01, 8'h14};
  logic [31:0] rd;
  logic [31:0] v;
  logic [7:0] su;
  logic [7:0] cm;
  logic set;
  always #10 mclk_i = ~mclk_i;
  pctm_card_timing i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(1'b1), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .card_oe_n_o(stb[3]), .card_we_n_o(stb[2]), .card_iord_n_o(stb[1]),
    .card_iowr_n_o(stb[0]), .busy_o(busy_o));
  pctm_card_model i_card (.mclk_i(mclk_i), .stb_n_i(stb), .low_len_o(len_seen), .kind_o(kind_seen));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int len(logic [7:0] r);
    return w[r[7:6]] * r[5:0] + 1;
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic edge_rdy();
    int k;
    k = 0;
    @(posedge mclk_i);
    while (hreadyout_o !== 1'b1)
    begin
      k++;
      if (k > 50)
      begin
        n_mismatch++;
        give_verdict();
      end
      @(posedge mclk_i);
    end
  endtask
  task automatic bus(logic wr, logic [7:0] idx, logic [7:0] d);
    @(posedge mclk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    haddr_i <= {22'h0, idx, 2'h0};
    edge_rdy();
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= {24'h0, d};
    edge_rdy();
    rd = hrdata_o;
  endtask
  // A negative setup figure skips the setup count when bus traffic overlapped it.
  task automatic run(logic [1:0] kind, int es, int ec);
    int s;
    int c;
    s = 0;
    c = 0;
    @(negedge mclk_i);
    chk(busy_o, 1'b1);
    while (busy_o === 1'b1 && stb === 4'hf && s < 9000)
    begin
      s++;
      @(negedge mclk_i);
    end
    while (busy_o === 1'b1 && c < 9000)
    begin
      c++;
      @(negedge mclk_i);
    end
    if (s == 9000 || c == 9000)
    begin
      n_mismatch++;
      give_verdict();
    end
    if (es >= 0)
      chk(s, es);
    chk(c, ec);
    chk(len_seen, ec);
    chk(kind_seen, kind);
  endtask
  initial
  begin
    repeat (2) @(posedge mclk_i);
    rstn_i <= 1'b1;
    foreach (ri[i])
    begin
      bus(1'b0, ri[i], 8'h00);
      chk(rd, {24'h0, rv[i]});
    end
    bus(1'b1, 8'h40, 8'h80);
    run(2'h0, 2, 6);
    bus(1'b1, 8'h40, 8'h88);
    run(2'h0, 2, 21);
    bus(1'b1, 8'h3c, 8'hff);
    bus(1'b0, 8'h3c, 8'h00);
    chk(rd, 32'h0);
    chk(hresp_o, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      v = rnd();
      su = {i[1:0], i[1] ? 6'h01 : v[5:0]};
      cm = {~i[1:0], i[1] ? v[11:6] : 6'h01};
      if (i == 4)
        su = 8'h00;
      if (i == 5)
        su = 8'h7f;
      set = i[1] ? (i[2] ? v[31] : v[27]) : v[12];
      bus(1'b1, set ? 8'h3d : 8'h3a, su);
      bus(1'b1, set ? 8'h3e : 8'h3b, cm);
      bus(1'b1, set ? 8'h3a : 8'h3d, 8'h09);
      bus(1'b1, set ? 8'h3b : 8'h3e, 8'h09);
      bus(1'b0, set ? 8'h3e : 8'h3b, 8'h00);
      chk(rd, {24'h0, cm});
      bus(1'b1, 8'h07, v[31:24]);
      bus(1'b1, 8'h40, {4'h8, v[12], i[2], i[1:0]});
      run(i[1:0], len(su), len(cm));
    end
    // A strobe width rewritten during setup must govern this very access.
    bus(1'b1, 8'h3a, 8'h41);
    bus(1'b1, 8'h40, 8'h81);
    bus(1'b1, 8'h3b, 8'h02);
    bus(1'b1, 8'h40, 8'h82);
    // Still in setup: busy, setup phase, timer set 0, memory write.
    bus(1'b0, 8'h41, 8'h00);
    chk(rd, 32'h00000013);
    run(2'h1, -1, 3);
    bus(1'b0, 8'h41, 8'h00);
    chk(rd, 32'h00000010);
    bus(1'b0, 8'h40, 8'h00);
    chk(rd, 32'h00000002);
    give_verdict();
  end
endmodule
